// file: sccl_osc_model.sv
`timescale 1ns/1ps
module sccl_osc_model (
    input wire logic clk_i,
    input wire logic main_oscillator_run_i,
    output logic main_oscillator_o,
    output logic internal_oscillator_o,
    output logic pll_tick_o
);
    logic [1:0] ph_q = 2'h0;
    initial begin
        main_oscillator_o = 1'b0;
        internal_oscillator_o = 1'b0;
        pll_tick_o = 1'b0;
    end
    always @(posedge clk_i) begin
        ph_q <= ph_q + 2'h1;
        // Stopping main oscillator models a dead crystal
        if (main_oscillator_run_i && ph_q == 2'h3) begin
            main_oscillator_o <= ~main_oscillator_o;
        end
        internal_oscillator_o <= ph_q[1];
        pll_tick_o <= ph_q[0];
    end
endmodule // sccl_osc_model

// file: sccl_top.sv
// Function
// - System clock divisor equals the divider field plus one.
// - PLL in use: encodings 0x0-0x6 and 0x8 reserved; 0x7 25 MHz.
// - Bypassed, raw oscillator is divided; encoding 0x0 acts as 0x1.
// - Crystal change is translated to PLL settings, readable read-only.
// - PLL Normal mode drives output; Power-Down mode drives nothing.
// - Relock on changed crystal value or PLL leaving Power-Down only.
// - Lock down-counter on main oscillator, loaded 0x1200, gates PLL use.
// - Enable and select PLL together: stay on oscillator until locked.
// - PLL lock reported as raw flag and as maskable interrupt.
// - PLL disabled after reset until software configures and enables it.
// - Three verification timers: PLL, internal, main oscillator checks.
// - Detected failure switches clock tree at once and interrupts.
// - Failure persists until clear register or reset; forced switch too, except in Deep-Sleep.
// - Each verification timer has its own enable bit.
// - Per-mode peripheral gating registers, writes masked by capabilities.
// - Sleep stops core clock; peripherals by sleep or run gating.
// - Deep-Sleep stops core clock; peripherals by deep or run gating.
// - Deep-Sleep runs main oscillator, or chosen internal one, main off.
// - PLL running at Deep-Sleep entry: PLL off, divider overridden.
// - Deep-Sleep exit restores clock before re-enabling stopped clocks.
// - Source field: 0x0 main, 0x1 internal, 0x2 internal over four.
package sccl_pkg;
    localparam logic [11:0] A_CAP0 = 12'h010;
    localparam logic [11:0] A_CAP1 = 12'h014;
    localparam logic [11:0] A_CAP2 = 12'h01C;
    localparam logic [11:0] A_RIS = 12'h050;
    localparam logic [11:0] A_IMC = 12'h054;
    localparam logic [11:0] A_MISC = 12'h058;
    localparam logic [11:0] A_RCC = 12'h060;
    localparam logic [11:0] A_PLL_TRANSLATION = 12'h064;
    localparam logic [11:0] A_DSLP = 12'h144;
    localparam logic [11:0] A_CLKV = 12'h150;
    localparam logic [3:0] A_GATE_PAGE = 4'h1;
    localparam logic [3:0] G_RUN = 4'h0;
    localparam logic [3:0] G_SLP = 4'h1;
    localparam logic [3:0] G_DSL = 4'h2;
    localparam logic [31:0] RCC_RST = 32'h0780_3AC0;
    localparam logic [31:0] DSLP_RST = 32'h0780_0000;
    localparam logic [95:0] GATE_RST = {64'h0, 32'h0000_0040};
    localparam int unsigned RIS_PLLL = 6;
    localparam int unsigned RIS_CLKF = 0;
    localparam int unsigned CLKV_BIT = 0;
    localparam logic [1:0] SRC_MAIN_OSCILLATOR = 2'h0;
    localparam logic [1:0] SRC_INTERNAL_OSCILLATOR = 2'h1;
    localparam logic [1:0] SRC_IOSC4 = 2'h2;
    localparam logic [1:0] SRC_PLL = 2'h3;
    localparam logic [6:0] DIV_ONE = 7'h01;
    localparam logic [6:0] DIV_TWO = 7'h02;
    localparam logic [1:0] INTERNAL_OSCILLATOR_Q4_LAST = 2'h3;
    localparam logic [5:0] INTERNAL_OSCILLATOR_Q64_LAST = 6'h3F;
    localparam int unsigned V_PLL = 0;
    localparam int unsigned V_INTERNAL_OSCILLATOR = 1;
    localparam int unsigned V_MAIN_OSCILLATOR = 2;
    localparam logic [8:0] XLAT_F_BASE = 9'h000;

    typedef struct packed {
        logic [3:0] rsv3;
        logic acg;
        logic [3:0] system_divider;
        logic use_system_divider;
        logic [7:0] rsv2;
        logic pwrdn;
        logic oen;
        logic bypass;
        logic pll_ver;
        logic [3:0] crystal_select;
        logic [1:0] oscillator_source;
        logic internal_oscillator_ver;
        logic main_oscillator_ver;
        logic [1:0] rsv0;
    } sccl_rcc_t;

    typedef struct packed {
        logic [2:0] rsv2;
        logic [5:0] div;
        logic [16:0] rsv1;
        logic [1:0] src;
        logic [3:0] rsv0;
    } sccl_dslp_t;

    typedef struct packed {
        logic [1:0] src;
        logic [6:0] div;
    } sccl_clk_t;

    typedef enum {M_RUN, M_SLEEP, M_DEEP, M_WAKE} sccl_mode_t;

    function automatic logic [31:0] sccl_xlat(input logic [3:0] x);
        return {18'h0_0000, 9'(XLAT_F_BASE + 9'(x)), 1'b0, x};
    endfunction

    function automatic logic [31:0] sccl_be(input logic [31:0] o,
                                            input logic [31:0] n,
                                            input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = n[8*b +: 8];
            end
        end
        return r;
    endfunction
endpackage

`timescale 1ns/1ps
module sccl_top #(
    parameter logic [15:0] LOCK_COUNT = 16'h1200,
    parameter logic [95:0] CAP_MASK = {3{32'hFFFF_FFFF}},
    parameter int unsigned VER_WIN = 8,
    parameter int unsigned VER_MIN = 1,
    parameter int unsigned VER_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [11:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic main_oscillator_pin_i,
    input wire logic internal_oscillator_pin_i,
    input wire logic pll_tick_i,
    input wire logic wfi_i,
    input wire logic sleepdeep_i,
    input wire logic wake_i,
    output logic sysclk_en_o,
    output logic cpu_clk_en_o,
    output logic [95:0] periph_clk_en_o,
    output logic pll_pd_o,
    output logic pll_oe_o,
    output logic [31:0] pll_cfg_o,
    output logic main_oscillator_pd_o,
    output logic irq_o
);
    import sccl_pkg::*;

    logic ack_q, hit, wr, g_hit;
    logic [31:0] dat_q, rd_d, ris_w;
    logic [1:0] gi;
    sccl_rcc_t rcc_q;
    sccl_dslp_t dslp_q;
    logic [31:0] imc_q, pll_cfg_q;
    logic [95:0] run_q, slp_q, dsl_q, gsel;
    logic [2:0] main_oscillator_s_q, internal_oscillator_s_q;
    logic main_oscillator_tk, internal_oscillator_tk, iosc4_tk, iosc64_tk;
    logic [1:0] q4_q;
    logic [5:0] q64_q;
    logic [3:0] crystal_select_seen_q;
    logic pd_prev_q, pll_pd, relock, locked, lock_prev_q, plll_q;
    logic [15:0] lk_q;
    logic [2:0] fail_q, v_en, v_ref, v_chk, v_fail, fail_now;
    logic clkv_wr;
    sccl_mode_t mode_q;
    logic pll_entry_q, use_pll, pulse, switch_now, src_tk;
    logic [1:0] osc;
    sccl_clk_t run_clk, deep_clk, want, cur_q;
    logic [6:0] cnt_q;
    logic sys_q, cpu_q;
    logic [95:0] pe_q;

    // Wishbone slave: one wait state, ack for any address
    assign hit = cyc_i & stb_i & ~ack_q;
    assign wr = hit & we_i;
    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign g_hit = adr_i[11:8] == A_GATE_PAGE && adr_i[3:2] != 2'h3
                   && (adr_i[7:4] == G_RUN || adr_i[7:4] == G_SLP
                       || adr_i[7:4] == G_DSL);
    assign gi = adr_i[3:2];
    assign clkv_wr = wr && adr_i == A_CLKV && sel_i[0] && dat_i[CLKV_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= hit;
            if (hit) begin
                dat_q <= rd_d;
            end
        end
    end

    always_comb begin
        ris_w = 32'h0000_0000;
        ris_w[RIS_PLLL] = plll_q;
        ris_w[RIS_CLKF] = |fail_q;
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        case (adr_i)
            A_CAP0: rd_d = CAP_MASK[31:0];
            A_CAP1: rd_d = CAP_MASK[63:32];
            A_CAP2: rd_d = CAP_MASK[95:64];
            A_RIS: rd_d = ris_w;
            A_IMC: rd_d = imc_q;
            A_MISC: rd_d = ris_w & imc_q;
            A_RCC: rd_d = rcc_q;
            A_PLL_TRANSLATION: rd_d = pll_cfg_q;
            A_DSLP: rd_d = dslp_q;
            default: begin
                if (g_hit && adr_i[7:4] == G_RUN) begin
                    rd_d = run_q[32*gi +: 32];
                end else if (g_hit && adr_i[7:4] == G_SLP) begin
                    rd_d = slp_q[32*gi +: 32];
                end else if (g_hit) begin
                    rd_d = dsl_q[32*gi +: 32];
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rcc_q <= RCC_RST;
            dslp_q <= DSLP_RST;
            imc_q <= 32'h0000_0000;
        end else if (wr) begin
            if (adr_i == A_RCC) begin
                rcc_q <= sccl_be(rcc_q, dat_i, sel_i);
            end
            if (adr_i == A_DSLP) begin
                dslp_q <= sccl_be(dslp_q, dat_i, sel_i);
            end
            if (adr_i == A_IMC) begin
                imc_q <= sccl_be(imc_q, dat_i, sel_i);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= GATE_RST;
            slp_q <= GATE_RST;
            dsl_q <= GATE_RST;
        end else if (wr && g_hit) begin
            if (adr_i[7:4] == G_RUN) begin
                run_q[32*gi +: 32] <= sccl_be(run_q[32*gi +: 32], dat_i, sel_i)
                                      & CAP_MASK[32*gi +: 32];
            end else if (adr_i[7:4] == G_SLP) begin
                slp_q[32*gi +: 32] <= sccl_be(slp_q[32*gi +: 32], dat_i, sel_i)
                                      & CAP_MASK[32*gi +: 32];
            end else begin
                dsl_q[32*gi +: 32] <= sccl_be(dsl_q[32*gi +: 32], dat_i, sel_i)
                                      & CAP_MASK[32*gi +: 32];
            end
        end
    end

    // Oscillator pins: two flops, then edge detect on the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_oscillator_s_q <= 3'h0;
            internal_oscillator_s_q <= 3'h0;
            q4_q <= 2'h0;
            q64_q <= 6'h00;
        end else begin
            main_oscillator_s_q <= {main_oscillator_s_q[1:0], main_oscillator_pin_i};
            internal_oscillator_s_q <= {internal_oscillator_s_q[1:0], internal_oscillator_pin_i};
            if (internal_oscillator_tk) begin
                q4_q <= 2'(q4_q + 2'h1);
                q64_q <= 6'(q64_q + 6'h01);
            end
        end
    end

    assign main_oscillator_tk = main_oscillator_s_q[1] & ~main_oscillator_s_q[2];
    assign internal_oscillator_tk = internal_oscillator_s_q[1] & ~internal_oscillator_s_q[2];
    assign iosc4_tk = internal_oscillator_tk && q4_q == INTERNAL_OSCILLATOR_Q4_LAST;
    assign iosc64_tk = internal_oscillator_tk && q64_q == INTERNAL_OSCILLATOR_Q64_LAST;

    assign pll_pd = rcc_q.pwrdn | (mode_q == M_DEEP && pll_entry_q);
    assign pll_pd_o = pll_pd;
    assign pll_oe_o = ~pll_pd & ~rcc_q.oen;
    assign pll_cfg_o = pll_cfg_q;
    assign relock = (rcc_q.crystal_select != crystal_select_seen_q) | (pd_prev_q & ~pll_pd);
    // Relock cycle counts as unlocked, so the PLL is dropped at once
    assign locked = lk_q == 16'h0000 && !pll_pd && !relock;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crystal_select_seen_q <= RCC_RST[9:6];
            pll_cfg_q <= sccl_xlat(RCC_RST[9:6]);
            pd_prev_q <= 1'b1;
        end else begin
            crystal_select_seen_q <= rcc_q.crystal_select;
            pd_prev_q <= pll_pd;
            if (rcc_q.crystal_select != crystal_select_seen_q) begin
                pll_cfg_q <= sccl_xlat(rcc_q.crystal_select);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || pll_pd || relock) begin
            lk_q <= LOCK_COUNT;
        end else if (main_oscillator_tk && lk_q != 16'h0000) begin
            lk_q <= 16'(lk_q - 16'h0001);
        end
    end

    // Sticky lock flag, set beats W1C
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_prev_q <= 1'b0;
            plll_q <= 1'b0;
        end else begin
            lock_prev_q <= locked;
            if (locked && !lock_prev_q) begin
                plll_q <= 1'b1;
            end else if (wr && adr_i == A_MISC && sel_i[0]
                         && dat_i[RIS_PLLL]) begin
                plll_q <= 1'b0;
            end
        end
    end

    always_comb begin
        v_en[V_PLL] = rcc_q.pll_ver && locked;
        v_en[V_INTERNAL_OSCILLATOR] = rcc_q.internal_oscillator_ver;
        v_en[V_MAIN_OSCILLATOR] = rcc_q.main_oscillator_ver;
        // Oscillators may be parked in low power, so checks pause there
        if (mode_q == M_DEEP || mode_q == M_WAKE) begin
            v_en = 3'h0;
        end
        v_ref = {iosc64_tk, main_oscillator_tk, main_oscillator_tk};
        v_chk = {main_oscillator_tk, internal_oscillator_tk, pll_tick_i};
    end

    for (genvar g = 0; g < 3; g++) begin : g_ver
        sccl_vtimer #(
            .WIN(VER_WIN),
            .MIN(VER_MIN),
            .W(VER_W)
        ) u_ver (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .en_i(v_en[g]),
            .ref_i(v_ref[g]),
            .chk_i(v_chk[g]),
            .fail_o(v_fail[g])
        );
    end

    // Failure persists; a new failure wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fail_q <= 3'h0;
        end else if (|v_fail) begin
            fail_q <= fail_q | v_fail;
        end else if (clkv_wr) begin
            fail_q <= 3'h0;
        end
    end

    // Failure interrupts regardless of mask; lock masked
    assign irq_o = |(ris_w & imc_q) | (|fail_q);

    // Fresh failures count at once, so the forced switch lands on a live clock
    assign fail_now = fail_q | v_fail;

    always_comb begin
        osc = rcc_q.oscillator_source;
        if (osc == SRC_PLL) begin
            osc = SRC_MAIN_OSCILLATOR;
        end
        if (fail_now[V_MAIN_OSCILLATOR] && osc == SRC_MAIN_OSCILLATOR) begin
            osc = SRC_INTERNAL_OSCILLATOR;
        end else if (fail_now[V_INTERNAL_OSCILLATOR] && osc != SRC_MAIN_OSCILLATOR) begin
            osc = SRC_MAIN_OSCILLATOR;
        end
    end

    assign use_pll = !rcc_q.bypass && locked && !fail_now[V_PLL];

    always_comb begin
        run_clk.src = use_pll ? SRC_PLL : osc;
        // Divisor is field plus one; reserved codes unchecked
        run_clk.div = 7'(rcc_q.system_divider) + DIV_ONE;
        if (!use_pll && !rcc_q.use_system_divider && rcc_q.bypass) begin
            run_clk.div = DIV_ONE;
        end else if (!use_pll && rcc_q.system_divider == 4'h0) begin
            run_clk.div = DIV_TWO;
        end
        // Deep source, main oscillator by default
        deep_clk.src = (dslp_q.src == SRC_PLL) ? SRC_MAIN_OSCILLATOR : dslp_q.src;
        // Divider override when PLL was running
        deep_clk.div = pll_entry_q ? 7'(dslp_q.div) + DIV_ONE : run_clk.div;
        want = (mode_q == M_DEEP) ? deep_clk : run_clk;
    end

    assign main_oscillator_pd_o = mode_q == M_DEEP && deep_clk.src != SRC_MAIN_OSCILLATOR;

    always_comb begin
        unique case (cur_q.src)
            SRC_MAIN_OSCILLATOR: src_tk = main_oscillator_tk;
            SRC_INTERNAL_OSCILLATOR: src_tk = internal_oscillator_tk;
            SRC_IOSC4: src_tk = iosc4_tk;
            SRC_PLL: src_tk = pll_tick_i;
        endcase
    end

    // Dead source cannot reach a boundary, so those cases switch at once
    assign switch_now = (|v_fail) || (cur_q.src == SRC_PLL && !use_pll);
    assign pulse = src_tk && cnt_q >= 7'(cur_q.div - DIV_ONE) && !switch_now;

    // New source or divider taken at a period boundary, or at once on switch_now
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_q <= {SRC_MAIN_OSCILLATOR, DIV_ONE};
            cnt_q <= 7'h00;
        end else if (switch_now || pulse) begin
            cur_q <= want;
            cnt_q <= 7'h00;
        end else if (src_tk) begin
            cnt_q <= 7'(cnt_q + 7'h01);
        end
    end

    always_comb begin
        gsel = run_q;
        if (mode_q == M_SLEEP && rcc_q.acg) begin
            gsel = slp_q;
        end else if ((mode_q == M_DEEP || mode_q == M_WAKE) && rcc_q.acg) begin
            gsel = dsl_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_q <= 1'b0;
            cpu_q <= 1'b0;
            pe_q <= '0;
        end else begin
            sys_q <= pulse;
            cpu_q <= pulse && mode_q == M_RUN;
            pe_q <= pulse ? gsel : '0;
        end
    end

    assign sysclk_en_o = sys_q;
    assign cpu_clk_en_o = cpu_q;
    assign periph_clk_en_o = pe_q;

    // Core picks the sleep depth; Deep-Sleep wake waits for clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= M_RUN;
            pll_entry_q <= 1'b0;
        end else begin
            unique case (mode_q)
                M_RUN: begin
                    if (wfi_i && sleepdeep_i) begin
                        mode_q <= M_DEEP;
                        pll_entry_q <= cur_q.src == SRC_PLL;
                    end else if (wfi_i) begin
                        mode_q <= M_SLEEP;
                    end
                end
                M_SLEEP: begin
                    if (wake_i) begin
                        mode_q <= M_RUN;
                    end
                end
                M_DEEP: begin
                    if (wake_i) begin
                        mode_q <= M_WAKE;
                    end
                end
                M_WAKE: begin
                    if (cur_q == run_clk && (!pll_entry_q || use_pll)) begin
                        mode_q <= M_RUN;
                        pll_entry_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_one_a: assert property (ack_q |=> !ack_q)
        else $error("ack held longer than one cycle");
    lock_gate_a: assert property (cur_q.src == SRC_PLL |-> lk_q == 16'h0000)
        else $error("PLL in use before lock count done");
    relock_load_a: assert property (relock && !pll_pd |=> lk_q == LOCK_COUNT)
        else $error("relock did not reload lock counter");
    xlat_upd_a: assert property (rcc_q.crystal_select != crystal_select_seen_q
        |=> pll_cfg_q == sccl_xlat($past(rcc_q.crystal_select)))
        else $error("crystal translation not updated");
    osc_wait_a: assert property (!locked |-> run_clk.src != SRC_PLL)
        else $error("PLL chosen while unlocked");
    fail_switch_a: assert property (|v_fail
        |=> cur_q == $past(want) && cnt_q == 7'h00 && irq_o)
        else $error("failure did not switch clock and interrupt");
    fail_away_a: assert property (fail_q[V_MAIN_OSCILLATOR] && !fail_q[V_INTERNAL_OSCILLATOR]
        && (mode_q == M_RUN || mode_q == M_SLEEP) |-> cur_q.src != SRC_MAIN_OSCILLATOR)
        else $error("clock tree left on failed main oscillator");
    fail_hold_a: assert property (|fail_q && !clkv_wr |=> |fail_q)
        else $error("failure flag dropped without clear");
    byp_div2_a: assert property (rcc_q.bypass && rcc_q.use_system_divider
        && rcc_q.system_divider == 4'h0 |-> run_clk.div == DIV_TWO)
        else $error("bypass encoding zero not divide by two");
    cpu_stop_a: assert property (cpu_q |-> $past(mode_q) == M_RUN)
        else $error("core clock ran outside run mode");
    deep_pll_a: assert property (mode_q == M_DEEP && pll_entry_q
        |-> pll_pd_o && !pll_oe_o)
        else $error("PLL left running in deep sleep");
    wake_rest_a: assert property ($past(mode_q) == M_WAKE
        && mode_q == M_RUN |-> $past(cur_q) == $past(run_clk))
        else $error("clocks enabled before clock restored");

    cover property (mode_q == M_DEEP && pll_entry_q ##[1:1000] mode_q == M_RUN);
    cover property ($rose(|fail_q));
    cover property (cur_q.src == SRC_PLL && sys_q);
    cover property (mode_q == M_SLEEP ##1 mode_q == M_RUN);
endmodule // sccl_top

// file: sccl_top_tb.sv
`timescale 1ns/1ps
module sccl_top_tb;
    import sccl_pkg::*;
    logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, run = 1;
    logic wfi_i = 0, sleepdeep_i = 0, wake_i = 0, mo, io, tk, ack_o;
    logic sysclk_en_o, cpu_clk_en_o, pll_pd_o, pll_oe_o, main_oscillator_pd_o, irq_o;
    logic [11:0] adr_i = 12'h000;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, rd, pll_cfg_o;
    logic [3:0] sel_i = 4'hF;
    logic [95:0] periph_clk_en_o;
    int n_fail = 0, n_compared = 0, cnt = 0, p;
    always #10 clk_i = ~clk_i;
    sccl_osc_model i_sccl_osc_model (.clk_i(clk_i), .main_oscillator_run_i(run),
        .main_oscillator_o(mo), .internal_oscillator_o(io), .pll_tick_o(tk));
    sccl_top #(.LOCK_COUNT(16'h0010)) i_sccl_top (.clk_i(clk_i),
        .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
        .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .ack_o(ack_o), .main_oscillator_pin_i(mo), .internal_oscillator_pin_i(io), .pll_tick_i(tk),
        .wfi_i(wfi_i), .sleepdeep_i(sleepdeep_i), .wake_i(wake_i),
        .sysclk_en_o(sysclk_en_o), .cpu_clk_en_o(cpu_clk_en_o),
        .periph_clk_en_o(periph_clk_en_o), .pll_pd_o(pll_pd_o),
        .pll_oe_o(pll_oe_o), .pll_cfg_o(pll_cfg_o), .main_oscillator_pd_o(main_oscillator_pd_o),
        .irq_o(irq_o));
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        adr_i <= a;
        we_i <= w;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        we_i <= 0;
    endtask
    // Second period only: divider changes land at period end
    task automatic meas(input logic [31:0] e);
        repeat (2) @(posedge clk_i iff sysclk_en_o === 1'b1);
        p = 0;
        do begin @(posedge clk_i); p++; end while (sysclk_en_o !== 1'b1);
        chk(p, e);
    endtask
    task automatic per(input logic [31:0] run_clock_config, input logic [31:0] e);
        wb(A_RCC, 1, run_clock_config);
        meas(e);
    endtask
    task automatic pulse(input logic to_wake);
        @(posedge clk_i);
        wfi_i <= !to_wake;
        wake_i <= to_wake;
        @(posedge clk_i);
        wfi_i <= 0;
        wake_i <= 0;
    endtask
    task automatic finish_test;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cnt++;
        if (cnt == 60000) begin
            n_fail++;
            finish_test;
        end
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        wb(A_RCC, 0, 0);
        chk(rd, 32'h0780_3AC0);
        chk(pll_pd_o, 1);
        chk(pll_cfg_o, {18'h0, XLAT_F_BASE + 9'h00B, 5'h0B});
        wb(A_DSLP, 0, 0);
        chk(rd, 32'h0780_0000);
        wb(12'h0FC, 0, 0);
        chk(rd, 0);
        $display("reset test done");
        per(32'h01C0_2AC0, 32);
        per(32'h0040_2AC0, 16);
        per(32'h01C0_2AD0, 16);
        per(32'h01C0_2AE0, 64);
        $display("divider test done");
        // Enable and select PLL in one write before lock
        wb(A_RCC, 1, 32'h03C0_0180);
        // Translation register updates one cycle after the write
        @(posedge clk_i);
        chk(pll_cfg_o, {18'h0, XLAT_F_BASE + 9'h006, 5'h06});
        chk(pll_pd_o, 0);
        chk(pll_oe_o, 1);
        wb(A_RIS, 0, 0);
        chk(rd[RIS_PLLL], 0);
        repeat (400) @(posedge clk_i);
        wb(A_RIS, 0, 0);
        chk(rd[RIS_PLLL], 1);
        per(32'h03C0_0180, 16);
        wb(A_MISC, 1, 32'h0000_0040);
        wb(A_RCC, 1, 32'h03C0_0180);
        repeat (400) @(posedge clk_i);
        wb(A_RIS, 0, 0);
        chk(rd[RIS_PLLL], 0);
        $display("pll test done");
        wb(12'h100, 1, 32'h0000_00FF);
        wb(12'h110, 1, 32'h0000_0003);
        wb(A_RCC, 1, 32'h0BC0_0180);
        pulse(0);
        // Skip a pulse that may have been launched in the old mode
        @(posedge clk_i);
        @(posedge clk_i iff sysclk_en_o === 1'b1);
        chk({cpu_clk_en_o, periph_clk_en_o[31:0]}, 33'h3);
        pulse(1);
        @(posedge clk_i);
        @(posedge clk_i iff sysclk_en_o === 1'b1);
        chk({cpu_clk_en_o, periph_clk_en_o[31:0]}, 33'h1_0000_00FF);
        wb(A_DSLP, 1, 32'h0780_0010);
        sleepdeep_i <= 1;
        pulse(0);
        repeat (8) @(posedge clk_i);
        chk({pll_pd_o, main_oscillator_pd_o, cpu_clk_en_o}, 3'b110);
        pulse(1);
        sleepdeep_i <= 0;
        repeat (600) @(posedge clk_i);
        chk({pll_pd_o, main_oscillator_pd_o}, 2'b00);
        $display("sleep test done");
        wb(A_RCC, 1, 32'h01C0_2AC4);
        run <= 0;
        // First check window may still see a late edge, so allow two windows
        repeat (5000) @(posedge clk_i);
        chk(irq_o, 1);
        // Forced onto internal oscillator, divide by four
        meas(16);
        run <= 1;
        repeat (500) @(posedge clk_i);
        wb(A_RIS, 0, 0);
        chk({irq_o, rd[RIS_CLKF]}, 2'b11);
        wb(A_CLKV, 1, 32'h0000_0001);
        @(posedge clk_i);
        chk(irq_o, 0);
        $display("failure test done");
        finish_test;
    end
endmodule // sccl_top_tb

// file: sccl_vtimer.sv
`timescale 1ns/1ps
module sccl_vtimer #(
    parameter int unsigned WIN = 8,
    parameter int unsigned MIN = 1,
    parameter int unsigned W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic ref_i,
    input wire logic chk_i,
    output logic fail_o
);
    logic [W-1:0] win_q;
    logic [W-1:0] hits_q;
    logic [W-1:0] hits_d;
    logic fail_q;

    // Saturate so a fast checked clock cannot wrap into a false failure
    assign hits_d = (chk_i && hits_q != {W{1'b1}}) ? W'(hits_q + 1'b1)
                                                   : hits_q;
    assign fail_o = fail_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            win_q <= '0;
            hits_q <= '0;
            fail_q <= 1'b0;
        end else begin
            fail_q <= 1'b0;
            if (ref_i && win_q == W'(WIN - 1)) begin
                win_q <= '0;
                hits_q <= '0;
                fail_q <= (hits_d < W'(MIN));
            end else begin
                if (ref_i) begin
                    win_q <= W'(win_q + 1'b1);
                end
                hits_q <= hits_d;
            end
        end
    end
endmodule // sccl_vtimer
